// ### logic/ghs_pkg.sv
// package: register map, reset values and carriers of the hibernate and serial line block
package ghs_pkg;

   // ----------------------------------------
   // register indices and byte addresses
   // ----------------------------------------
   localparam logic [31:0] GHS_IDX_HIB_KEEP = 32'h0b000318;
   localparam logic [31:0] GHS_IDX_SER_CTL  = 32'h0b00031a;
   localparam logic [31:0] GHS_IDX_PIN_SEL  = 32'h0b000340;
   localparam logic [31:0] GHS_IDX_STATUS   = 32'h0b000342;
   localparam logic [31:0] GHS_ADR_HIB_KEEP = GHS_IDX_HIB_KEEP << 2;
   localparam logic [31:0] GHS_ADR_SER_CTL  = GHS_IDX_SER_CTL << 2;
   localparam logic [31:0] GHS_ADR_PIN_SEL  = GHS_IDX_PIN_SEL << 2;
   localparam logic [31:0] GHS_ADR_STATUS   = GHS_IDX_STATUS << 2;

   // ----------------------------------------
   // serial line control fields
   // ----------------------------------------
   localparam int GHS_BIT_CH1_LOOP = 15;
   localparam int GHS_BIT_CH1_RXD  = 11;
   localparam int GHS_BIT_CH1_CTS  = 10;
   localparam int GHS_BIT_CH1_DSR  = 9;
   localparam int GHS_BIT_CH1_DCD  = 8;
   localparam int GHS_BIT_CH2_LOOP = 7;
   localparam int GHS_BIT_CH2_CTS  = 2;
   localparam int GHS_BIT_CH2_DSR  = 1;
   localparam int GHS_BIT_CH2_DCD  = 0;
   localparam logic [15:0] GHS_SER_CTL_WMASK = 16'h8f87;

   // ----------------------------------------
   // values after the rtc domain reset
   // ----------------------------------------
   localparam logic [15:0] GHS_RST_HIB_KEEP = 16'h0000;
   localparam logic [15:0] GHS_RST_SER_CTL  = 16'h0f07;
   localparam logic [6:0]  GHS_RST_PIN_SEL  = 7'h00;

   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   localparam logic [1:0] GHS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] GHS_RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // serial line input set, one bit per line
   // ----------------------------------------
   typedef struct packed {
      logic rxd1;
      logic cts1_n;
      logic dsr1_n;
      logic dcd1_n;
      logic cts2_n;
      logic dsr2_n;
      logic dcd2_n;
   } ghs_lines_s;

   // modem outputs of one channel
   typedef struct packed {
      logic dtr_n;
      logic rts_n;
   } ghs_modem_s;

endpackage

// ### logic/ghs_top.sv
// module: hibernate pin keep control and serial line input source selection, AXI4-Lite slave
//
// What this block does
// - keep bit 0: output floats, input ignored
// - keep bit 1: output driven, input monitored
// - wake only from pins with keep set
// - rtc reset clears keep and pin select, sets control to 0f07; other resets keep values
// - ch1 loop: dtr to dsr, rts to cts
// - ch2 loop: dtr to dsr, rts to cts
// - ch1 rxd from bit 11 without pin
// - ch1 cts from bit 10 otherwise
// - ch1 dsr from bit 9 otherwise
// - ch1 dcd from bit 8 without pin
// - ch2 cts from bit 2 otherwise
// - ch2 dsr from bit 1 otherwise
// - ch2 dcd from bit 0 without pin
// - reserved control bits read as zero
`timescale 1ns/1ps
module ghs_top #(
   parameter int NPIN = 16
) (
   input  wire logic                I_CLK,
   input  wire logic                I_RST_B,
   input  wire logic                I_RTC_RST_B,
   input  wire logic [31:0]         S_AXI_AWADDR,
   input  wire logic [2:0]          S_AXI_AWPROT,
   input  wire logic                S_AXI_AWVALID,
   output wire logic                S_AXI_AWREADY,
   input  wire logic [31:0]         S_AXI_WDATA,
   input  wire logic [3:0]          S_AXI_WSTRB,
   input  wire logic                S_AXI_WVALID,
   output wire logic                S_AXI_WREADY,
   output wire logic [1:0]          S_AXI_BRESP,
   output wire logic                S_AXI_BVALID,
   input  wire logic                S_AXI_BREADY,
   input  wire logic [31:0]         S_AXI_ARADDR,
   input  wire logic [2:0]          S_AXI_ARPROT,
   input  wire logic                S_AXI_ARVALID,
   output wire logic                S_AXI_ARREADY,
   output wire logic [31:0]         S_AXI_RDATA,
   output wire logic [1:0]          S_AXI_RRESP,
   output wire logic                S_AXI_RVALID,
   input  wire logic                S_AXI_RREADY,
   input  wire logic                i_hib_mode,
   input  wire logic [NPIN-1:0]     i_gpio_pin_in,
   input  wire logic [NPIN-1:0]     i_gpio_core_out,
   input  wire logic [NPIN-1:0]     i_gpio_core_oe,
   output logic      [NPIN-1:0]     o_gpio_pin_out,
   output logic      [NPIN-1:0]     o_gpio_pin_oe,
   output logic      [NPIN-1:0]     o_gpio_core_in,
   output logic                     o_wake,
   input  wire ghs_pkg::ghs_lines_s i_line_pin,
   input  wire ghs_pkg::ghs_modem_s i_ch1_modem,
   input  wire ghs_pkg::ghs_modem_s i_ch2_modem,
   output ghs_pkg::ghs_lines_s      o_line_to_ser
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (NPIN < 1 || NPIN > 16) begin : g_bad_npin
      $error("ghs_top: NPIN must be 1 to 16");
   end

   // ----------------------------------------
   // resets
   // ----------------------------------------
   // bus state follows every reset; stored settings only the rtc one
   wire bus_rst = !I_RST_B || !I_RTC_RST_B;
   wire cfg_rst = !I_RTC_RST_B;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [15:0] hib_pin_keep_r;
   logic [15:0] hib_pin_keep_nxt;
   logic [15:0] ser_ctl_r;
   logic [15:0] ser_ctl_nxt;
   logic [6:0]  pin_sel_r;
   logic [6:0]  pin_sel_nxt;

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   logic        aw_held_r;
   logic [31:0] aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;

   wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_hs  = S_AXI_WVALID && S_AXI_WREADY;
   assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
   assign S_AXI_WREADY  = !w_held_r && !bvalid_r;

   // address and data may come in either order
   wire        aw_have = aw_held_r || aw_hs;
   wire        w_have  = w_held_r || w_hs;
   wire        do_wr   = aw_have && w_have && !bvalid_r;
   wire [31:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
   wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA;
   wire [3:0]  wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB;

   wire wr_hib = wr_addr == ghs_pkg::GHS_ADR_HIB_KEEP;
   wire wr_ser = wr_addr == ghs_pkg::GHS_ADR_SER_CTL;
   wire wr_sel = wr_addr == ghs_pkg::GHS_ADR_PIN_SEL;
   wire wr_sts = wr_addr == ghs_pkg::GHS_ADR_STATUS;
   wire wr_hit = wr_hib || wr_ser || wr_sel || wr_sts;

   // byte lanes 0 and 1 carry the 16-bit registers
   wire [15:0] wr_bmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [15:0] wr_new   = wr_data[15:0];

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 32'h0000_0000;
      end else if (do_wr) begin
         aw_held_r <= 1'b0;
      end else if (aw_hs) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= S_AXI_AWADDR;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (do_wr) begin
         w_held_r <= 1'b0;
      end else if (w_hs) begin
         w_held_r <= 1'b1;
         w_data_r <= S_AXI_WDATA;
         w_strb_r <= S_AXI_WSTRB;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= ghs_pkg::GHS_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? ghs_pkg::GHS_RESP_OKAY : ghs_pkg::GHS_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP  = bresp_r;

   // ----------------------------------------
   // register updates
   // ----------------------------------------
   assign hib_pin_keep_nxt = (do_wr && wr_hib) ?
                             ((hib_pin_keep_r & ~wr_bmask) | (wr_new & wr_bmask)) : hib_pin_keep_r;
   assign ser_ctl_nxt      = (do_wr && wr_ser) ?
                             (((ser_ctl_r & ~wr_bmask) | (wr_new & wr_bmask)) & ghs_pkg::GHS_SER_CTL_WMASK) :
                             ser_ctl_r;
   assign pin_sel_nxt      = (do_wr && wr_sel && wr_strb[0]) ? wr_new[6:0] : pin_sel_r;

   always_ff @(posedge I_CLK) begin
      if (cfg_rst) begin
         hib_pin_keep_r <= ghs_pkg::GHS_RST_HIB_KEEP;
         ser_ctl_r      <= ghs_pkg::GHS_RST_SER_CTL;
         pin_sel_r      <= ghs_pkg::GHS_RST_PIN_SEL;
      end else begin
         hib_pin_keep_r <= hib_pin_keep_nxt;
         ser_ctl_r      <= ser_ctl_nxt;
         pin_sel_r      <= pin_sel_nxt;
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [15:0] status_w;

   wire ar_hs  = S_AXI_ARVALID && S_AXI_ARREADY;
   wire rd_hib = S_AXI_ARADDR == ghs_pkg::GHS_ADR_HIB_KEEP;
   wire rd_ser = S_AXI_ARADDR == ghs_pkg::GHS_ADR_SER_CTL;
   wire rd_sel = S_AXI_ARADDR == ghs_pkg::GHS_ADR_PIN_SEL;
   wire rd_sts = S_AXI_ARADDR == ghs_pkg::GHS_ADR_STATUS;
   wire rd_hit = rd_hib || rd_ser || rd_sel || rd_sts;

   // upper half always zero; unmapped reads return zero data
   wire [15:0] rd_val = rd_hib ? hib_pin_keep_r :
                        rd_ser ? ser_ctl_r :
                        rd_sel ? {9'h000, pin_sel_r} :
                        rd_sts ? status_w : 16'h0000;

   assign S_AXI_ARREADY = !rvalid_r;

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= ghs_pkg::GHS_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r  <= {16'h0000, rd_val};
         rresp_r  <= rd_hit ? ghs_pkg::GHS_RESP_OKAY : ghs_pkg::GHS_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA  = rdata_r;
   assign S_AXI_RRESP  = rresp_r;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [NPIN-1:0]     gpio_s1_r;
   logic [NPIN-1:0]     gpio_s2_r;
   logic [NPIN-1:0]     gpio_last_r;
   ghs_pkg::ghs_lines_s line_s1_r;
   ghs_pkg::ghs_lines_s line_s2_r;

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         gpio_s1_r <= '0;
         gpio_s2_r <= '0;
         line_s1_r <= '0;
         line_s2_r <= '0;
      end else begin
         gpio_s1_r <= i_gpio_pin_in;
         gpio_s2_r <= gpio_s1_r;
         line_s1_r <= i_line_pin;
         line_s2_r <= line_s1_r;
      end
   end

   // ----------------------------------------
   // wake arming
   // ----------------------------------------
   // synchronisers refill from zero after reset; comparing then would fake a pin edge
   logic [1:0] wake_arm_r;
   wire        wake_armed = wake_arm_r == 2'h3;

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         wake_arm_r <= 2'h0;
      end else if (!wake_armed) begin
         wake_arm_r <= wake_arm_r + 2'h1;
      end
   end

   // ----------------------------------------
   // hibernate pin gating, one slice per pin
   // ----------------------------------------
   logic [NPIN-1:0] keep_w;
   logic [NPIN-1:0] live_w;
   logic [NPIN-1:0] wake_hit_w;

   for (genvar p = 0; p < NPIN; p++) begin : g_pin
      assign keep_w[p] = hib_pin_keep_r[p];
      // pin live outside hibernate or when kept
      assign live_w[p] = !i_hib_mode || keep_w[p];
      assign wake_hit_w[p] = wake_armed && i_hib_mode && keep_w[p] && (gpio_s2_r[p] != gpio_last_r[p]);
   end

   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         gpio_last_r    <= '0;
         o_gpio_pin_out <= '0;
         o_gpio_pin_oe  <= '0;
         o_gpio_core_in <= '0;
         o_wake         <= 1'b0;
      end else begin
         gpio_last_r    <= gpio_s2_r;
         o_gpio_pin_out <= i_gpio_core_out;
         o_gpio_pin_oe  <= i_gpio_core_oe & live_w;
         o_gpio_core_in <= gpio_s2_r & live_w;
         o_wake         <= |wake_hit_w;
      end
   end

   // ----------------------------------------
   // serial line source selection
   // ----------------------------------------
   ghs_pkg::ghs_lines_s sel_w;
   ghs_pkg::ghs_lines_s pin_v;
   ghs_pkg::ghs_lines_s line_nxt;

   assign sel_w = pin_sel_r;
   assign pin_v = line_s2_r;

   wire loop1 = ser_ctl_r[ghs_pkg::GHS_BIT_CH1_LOOP];
   wire loop2 = ser_ctl_r[ghs_pkg::GHS_BIT_CH2_LOOP];

   // pin wins, then loop, then register
   assign line_nxt.rxd1   = sel_w.rxd1 ? pin_v.rxd1 : ser_ctl_r[ghs_pkg::GHS_BIT_CH1_RXD];
   assign line_nxt.cts1_n = sel_w.cts1_n ? pin_v.cts1_n :
                            loop1 ? i_ch1_modem.rts_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH1_CTS];
   assign line_nxt.dsr1_n = sel_w.dsr1_n ? pin_v.dsr1_n :
                            loop1 ? i_ch1_modem.dtr_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH1_DSR];
   assign line_nxt.dcd1_n = sel_w.dcd1_n ? pin_v.dcd1_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH1_DCD];
   assign line_nxt.cts2_n = sel_w.cts2_n ? pin_v.cts2_n :
                            loop2 ? i_ch2_modem.rts_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH2_CTS];
   assign line_nxt.dsr2_n = sel_w.dsr2_n ? pin_v.dsr2_n :
                            loop2 ? i_ch2_modem.dtr_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH2_DSR];
   assign line_nxt.dcd2_n = sel_w.dcd2_n ? pin_v.dcd2_n : ser_ctl_r[ghs_pkg::GHS_BIT_CH2_DCD];

   // registered so the channel never sees a decode glitch; costs one cycle
   always_ff @(posedge I_CLK) begin
      if (bus_rst) begin
         o_line_to_ser <= ghs_pkg::ghs_lines_s'(7'h7f);
      end else begin
         o_line_to_ser <= line_nxt;
      end
   end

   // ----------------------------------------
   // status view
   // ----------------------------------------
   // live line values and hibernate flag for software
   assign status_w = {i_hib_mode, o_wake, 7'h00, o_line_to_ser};

endmodule // ghs_top

// ### tb/ghs_partner.sv
// partner: serial channel modem outputs and external pin levels
`timescale 1ns/1ps
module ghs_partner (
   input  wire logic           i_clk,
   input  wire logic [3:0]     i_modem_set,
   input  wire logic [6:0]     i_line_set,
   input  wire logic [15:0]    i_pin_set,
   output ghs_pkg::ghs_modem_s o_ch1_modem = '0,
   output ghs_pkg::ghs_modem_s o_ch2_modem = '0,
   output ghs_pkg::ghs_lines_s o_line_pin = '0,
   output logic [15:0]         o_pin = '0
);
   // levels move just after the edge, like a registered channel
   always @(posedge i_clk) begin
      {o_ch1_modem, o_ch2_modem} <= i_modem_set;
      o_line_pin <= i_line_set;
      o_pin <= i_pin_set;
   end
endmodule // ghs_partner

// ### tb/ghs_assertions.sv
// checker: port-level properties of the hibernate and serial line block
`timescale 1ns/1ps
module ghs_assertions #(
   parameter int NPIN = 16
) (
   input wire logic                I_CLK,
   input wire logic                I_RST_B,
   input wire logic                I_RTC_RST_B,
   input wire logic [31:0]         S_AXI_AWADDR,
   input wire logic                S_AXI_AWVALID,
   input wire logic                S_AXI_AWREADY,
   input wire logic [31:0]         S_AXI_WDATA,
   input wire logic                S_AXI_WVALID,
   input wire logic                S_AXI_WREADY,
   input wire logic                i_hib_mode,
   input wire logic [NPIN-1:0]     i_gpio_core_oe,
   input wire logic [NPIN-1:0]     o_gpio_pin_oe,
   input wire logic                o_wake,
   input wire ghs_pkg::ghs_modem_s i_ch1_modem,
   input wire ghs_pkg::ghs_modem_s i_ch2_modem,
   input wire ghs_pkg::ghs_lines_s o_line_to_ser
);
   // ----------------------------------------
   // register shadow
   // ----------------------------------------
   // limitation: only tracks writes whose address and data are taken together
   logic [15:0]     ctl_r;
   logic [6:0]      sel_r;
   logic [NPIN-1:0] keep_r;
   wire logic       wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   always_ff @(posedge I_CLK) begin
      if (!I_RTC_RST_B) begin
         ctl_r <= 16'h0f07;
         sel_r <= 7'h00;
         keep_r <= '0;
      end else if (wr_go) begin
         if (S_AXI_AWADDR == ghs_pkg::GHS_ADR_SER_CTL) ctl_r <= S_AXI_WDATA[15:0] & 16'h8f87;
         if (S_AXI_AWADDR == ghs_pkg::GHS_ADR_PIN_SEL) sel_r <= S_AXI_WDATA[6:0];
         if (S_AXI_AWADDR == ghs_pkg::GHS_ADR_HIB_KEEP) keep_r <= S_AXI_WDATA[NPIN-1:0];
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B || !I_RTC_RST_B);
   property p_unkept_float; $past(i_hib_mode) |-> (o_gpio_pin_oe & ~$past(keep_r)) == '0; endproperty
   a_unkept_float: assert property (p_unkept_float) else $error("unkept pin driven in hibernate");
   // outputs still hold their reset value at the first edge after release
   property p_kept_drive;
      $past(I_RST_B) && $past(I_RTC_RST_B) && $past(i_hib_mode) |->
         (o_gpio_pin_oe & $past(keep_r)) == ($past(i_gpio_core_oe) & $past(keep_r));
   endproperty
   a_kept_drive: assert property (p_kept_drive) else $error("kept pin not driven");
   property p_wake_hib; o_wake |-> $past(i_hib_mode); endproperty
   a_wake_hib: assert property (p_wake_hib) else $error("wake outside hibernate");
   property p_loop1; !sel_r[5] && !sel_r[4] && ctl_r[15] |=>
      {o_line_to_ser.cts1_n, o_line_to_ser.dsr1_n} ==
      {$past(i_ch1_modem.rts_n), $past(i_ch1_modem.dtr_n)}; endproperty
   a_loop1: assert property (p_loop1) else $error("ch1 loop path wrong");
   property p_loop2; !sel_r[2] && !sel_r[1] && ctl_r[7] |=>
      {o_line_to_ser.cts2_n, o_line_to_ser.dsr2_n} ==
      {$past(i_ch2_modem.rts_n), $past(i_ch2_modem.dtr_n)}; endproperty
   a_loop2: assert property (p_loop2) else $error("ch2 loop path wrong");
   property p_rxd1; !sel_r[6] |=> o_line_to_ser.rxd1 == $past(ctl_r[11]); endproperty
   a_rxd1: assert property (p_rxd1) else $error("ch1 rx soft value wrong");
   property p_cts1; !sel_r[5] && !ctl_r[15] |=> o_line_to_ser.cts1_n == $past(ctl_r[10]); endproperty
   a_cts1: assert property (p_cts1) else $error("ch1 cts soft value wrong");
   property p_dcd1; !sel_r[3] |=> o_line_to_ser.dcd1_n == $past(ctl_r[8]); endproperty
   a_dcd1: assert property (p_dcd1) else $error("ch1 dcd soft value wrong");
endmodule // ghs_assertions

bind ghs_top ghs_assertions #(.NPIN(NPIN)) u_chk (
   .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_RTC_RST_B(I_RTC_RST_B), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .i_hib_mode(i_hib_mode),
   .i_gpio_core_oe(i_gpio_core_oe), .o_gpio_pin_oe(o_gpio_pin_oe), .o_wake(o_wake),
   .i_ch1_modem(i_ch1_modem), .i_ch2_modem(i_ch2_modem), .o_line_to_ser(o_line_to_ser)
);

// ### tb/test_gpio_hibernate_and_serial_line_source.sv
// testbench: bus access, line source choice and hibernate pin keeping
`timescale 1ns/1ps
module test_gpio_hibernate_and_serial_line_source;
   localparam logic [31:0] A_KEEP = ghs_pkg::GHS_ADR_HIB_KEEP;
   localparam logic [31:0] A_CTL  = ghs_pkg::GHS_ADR_SER_CTL;
   localparam logic [31:0] A_SEL  = ghs_pkg::GHS_ADR_PIN_SEL;
   logic        clk = 1'b0, rst_b = 1'b0, rtc_b = 1'b0, hib = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [31:0] awa = '0, wd = '0, ara = '0;
   logic [15:0] c_out = '0, c_oe = '0, p_set = '0;
   logic [3:0]  m_set = '0;
   logic [6:0]  l_set = '0;
   int          err_count = 0, n_checks = 0, cycles = 0, wakes = 0;
   wire logic        awr, wr, bv, arr, rv, wake;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rd_d;
   wire logic [15:0] p_out, p_oe, c_in, p_in;
   wire ghs_pkg::ghs_modem_s m1, m2;
   wire ghs_pkg::ghs_lines_s l_pin, l_out;
   ghs_top dut_u (
      .I_CLK(clk), .I_RST_B(rst_b), .I_RTC_RST_B(rtc_b),
      .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
      .i_hib_mode(hib), .i_gpio_pin_in(p_in), .i_gpio_core_out(c_out), .i_gpio_core_oe(c_oe),
      .o_gpio_pin_out(p_out), .o_gpio_pin_oe(p_oe), .o_gpio_core_in(c_in), .o_wake(wake),
      .i_line_pin(l_pin), .i_ch1_modem(m1), .i_ch2_modem(m2), .o_line_to_ser(l_out)
   );
   ghs_partner far_u (
      .i_clk(clk), .i_modem_set(m_set), .i_line_set(l_set), .i_pin_set(p_set),
      .o_ch1_modem(m1), .o_ch2_modem(m2), .o_line_pin(l_pin), .o_pin(p_in)
   );
   // ----------------------------------------
   // clock, watchdog, wake counter
   // ----------------------------------------
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (wake === 1'b1)
         wakes++;
      if (cycles == 4000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // address and data offered together; a hang is cut by the watchdog
   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      chk(br, er);
      bry <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      chk(rd_d, ed);
      chk(rr, er);
      rry <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input logic rtc);
      rst_b <= 1'b0;
      rtc_b <= !rtc;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rtc_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_regs();
      bus_rd(A_KEEP, 32'h0, 2'h0);
      bus_rd(A_CTL, 32'h0f07, 2'h0);
      bus_rd(32'h100, 32'h0, 2'h2);
      bus_wr(32'h100, 32'hffff, 2'h2);
      bus_wr(A_KEEP, 32'hffff, 2'h0);
      bus_wr(A_CTL, 32'hffff, 2'h0);
      bus_rd(A_CTL, 32'h8f87, 2'h0);
      pulse(1'b0);
      bus_rd(A_KEEP, 32'hffff, 2'h0);
      bus_rd(A_CTL, 32'h8f87, 2'h0);
      pulse(1'b1);
      bus_rd(A_KEEP, 32'h0, 2'h0);
      bus_rd(A_CTL, 32'h0f07, 2'h0);
   endtask
   task automatic t_soft();
      logic [15:0] v [3] = '{16'h0f07, 16'h0a05, 16'h0502};
      logic [6:0]  e [3] = '{7'h7f, 7'h55, 7'h2a};
      for (int i = 0; i < 3; i++) begin
         bus_wr(A_CTL, {16'h0, v[i]}, 2'h0);
         repeat (2) @(posedge clk);
         chk(l_out, e[i]);
      end
   endtask
   task automatic t_loop();
      bus_wr(A_CTL, 32'h8080, 2'h0);
      m_set <= 4'b1001;
      repeat (3) @(posedge clk);
      chk(l_out, 7'h14);
      bus_wr(A_CTL, 32'h8181, 2'h0);
      m_set <= 4'b0110;
      repeat (3) @(posedge clk);
      chk(l_out, 7'h2b);
   endtask
   // pins beat the loop that is still enabled
   task automatic t_pin();
      bus_wr(A_SEL, 32'h7f, 2'h0);
      bus_rd(A_SEL, 32'h7f, 2'h0);
      l_set <= 7'h55;
      repeat (6) @(posedge clk);
      chk(l_out, 7'h55);
      l_set <= 7'h2a;
      repeat (6) @(posedge clk);
      chk(l_out, 7'h2a);
      bus_wr(A_SEL, 32'h0, 2'h0);
   endtask
   task automatic t_hib();
      bus_wr(A_KEEP, 32'h00ff, 2'h0);
      c_oe <= 16'hffff;
      c_out <= 16'ha5a5;
      p_set <= 16'h1234;
      hib <= 1'b1;
      repeat (8) @(posedge clk);
      chk(p_oe, 16'h00ff);
      chk(p_out, 16'ha5a5);
      chk(c_in, 16'h0034);
      wakes = 0;
      p_set <= 16'h1334;
      repeat (8) @(posedge clk);
      chk(wakes, 0);
      p_set <= 16'h1335;
      repeat (8) @(posedge clk);
      chk(wakes, 1);
      // general reset while hibernating: no false wake, keep bits survive
      wakes = 0;
      pulse(1'b0);
      repeat (4) @(posedge clk);
      chk(wakes, 0);
      chk(p_oe, 16'h00ff);
      bus_rd(ghs_pkg::GHS_ADR_STATUS, 32'h802b, 2'h0);
      hib <= 1'b0;
      repeat (6) @(posedge clk);
      chk(c_in, 16'h1335);
   endtask
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rtc_b <= 1'b1;
      @(posedge clk);
      t_regs();
      t_soft();
      t_loop();
      t_pin();
      t_hib();
      end_of_test();
   end
endmodule // test_gpio_hibernate_and_serial_line_source
